// >>> hdl/psr_status_bank.sv
// paged status readout bank with axi4-lite slave and completion interrupt
//
// Summary of operation
// - page shown at 2Ch chosen by two-bit selector in page register bits 5:4
// - tuning_range_and_pin_level: range result in bits 7:4, bit 3 reads one
// - tuning_range_and_pin_level: bits 2:0 hold tuning pin voltage measurement
// - filter_calibration_codes: highpass code bits 7:4, lowpass code bits 3:0
// - converter_result: converter result, valid 20 us after command 87h
// - converter input is mixer I, mixer Q or external pin per select field
// - oscillator_and_supply_status bit 7: zero crystal, one compensated oscillator
// - oscillator_and_supply_status bits 2:0: supply level code, 2.7 V to 3.4 V
// - oscillator_and_supply_status bits 6:3 read zero
// - 2Eh bit 6 set on range selection done, raises interrupt event
// - 2Eh bit 4 set on filter calibration done, raises interrupt event
// - 2Eh bit 3 set on conversion done, raises interrupt event
// - 2Eh bit 2 reads one while anti-collision support enabled
// - 2Eh bit 1 set after gain limiter on, cleared after off completes
// - 2Eh bit 0 set after hop to auxiliary, cleared after hop to main
// - 33h returns fixed eight-bit version code
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module psr_status_bank #(
  parameter int ADDR_W = 12,
  parameter logic [7:0] DEVICE_VERSION = 8'h5A, // arbitrary value
  parameter int CONV_CYCLES_P = psr_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // direct command decoder
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  // engine completion pulses
  input wire logic range_sel_done,
  input wire logic supply_set_done,
  input wire logic filter_cal_done,
  input wire logic gain_limit_done,
  input wire logic synth_hop_done,
  // engine results
  input wire logic [3:0] tuning_range_result,
  input wire logic [2:0] tuning_pin_level,
  input wire logic [3:0] highpass_trim_code,
  input wire logic [3:0] lowpass_trim_code,
  input wire logic [7:0] adc_sample,
  input wire logic [2:0] supply_level_code,
  input wire logic anticollision_support_on,
  // oscillator input shorted to ground, asynchronous pin
  input wire logic osc_input_grounded,
  // converter control and interrupt
  output logic [1:0] conv_input_select,
  output logic conv_busy,
  output logic irq
);
  import psr_pkg::*;

  logic [7:0] page_sel_r;
  logic [7:0] int_stat_r;
  logic [7:0] int_mask_r;
  logic [7:0] cmd_stat_r;
  logic [7:0] conv_result_r;
  logic [1:0] osc_sync_r;
  logic gain_pending_on_r;
  logic hop_pending_aux_r;
  logic conv_start;
  logic conv_busy_w;
  logic conv_done;
  logic [7:0] events;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_held_r;
  logic w_held_r;
  logic wr_fire;
  logic rd_fire;
  logic rd_int_stat;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [1:0] tune_page;
  logic [1:0] conv_page;

  function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    idx_hit = (addr == ADDR_W'({idx, 2'b00}));
  endfunction : idx_hit

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] byte_addr);
    addr_hit = (addr == ADDR_W'(byte_addr));
  endfunction : addr_hit

  function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] a, input logic [7:0] b);
    is_cmd = (code == a) || (code == b);
  endfunction : is_cmd

  assign tune_page = page_sel_r[TUNE_PAGE_LSB +: 2];
  assign conv_page = page_sel_r[CONV_PAGE_LSB +: 2];
  assign conv_start = cmd_strobe && (cmd_code == CMD_CONV_TRIG);

  // oscillator detect pin crosses into aclk before anyone reads it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_sync_r <= 2'b00;
    else
      osc_sync_r <= {osc_sync_r[0], osc_input_grounded};
  end

  psr_conv_timer #(
    .CYCLES(CONV_CYCLES_P),
    .CNT_W(12)
  ) u_conv_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(conv_start),
    .busy(conv_busy_w),
    .done(conv_done)
  );

  // result is captured only when the settle time has run out
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_result_r <= 8'h00;
    else if (conv_done)
      conv_result_r <= adc_sample;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_busy <= 1'b0;
    else
      conv_busy <= conv_busy_w;
  end

  // remember which of a command pair is running so the shared done pulse resolves it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_pending_on_r <= 1'b0;
      hop_pending_aux_r <= 1'b0;
    end
    else if (cmd_strobe)
    begin
      if (is_cmd(cmd_code, CMD_GAIN_ON, CMD_GAIN_OFF))
        gain_pending_on_r <= (cmd_code == CMD_GAIN_ON);
      if (is_cmd(cmd_code, CMD_HOP_MAIN, CMD_HOP_AUX))
        hop_pending_aux_r <= (cmd_code == CMD_HOP_AUX);
    end
  end

  // done flags clear when their command is issued again; a done in that cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmd_stat_r <= 8'h00;
    else
    begin
      if (range_sel_done)
        cmd_stat_r[RANGE_DONE_BIT] <= 1'b1;
      else if (cmd_strobe && is_cmd(cmd_code, CMD_RANGE_AUTO, CMD_RANGE_MAN))
        cmd_stat_r[RANGE_DONE_BIT] <= 1'b0;
      if (supply_set_done)
        cmd_stat_r[SUPPLY_DONE_BIT] <= 1'b1;
      else if (cmd_strobe && is_cmd(cmd_code, CMD_SUPPLY_AUTO, CMD_SUPPLY_MAN))
        cmd_stat_r[SUPPLY_DONE_BIT] <= 1'b0;
      if (filter_cal_done)
        cmd_stat_r[FILTER_DONE_BIT] <= 1'b1;
      else if (cmd_strobe && (cmd_code == CMD_FILTER_CAL))
        cmd_stat_r[FILTER_DONE_BIT] <= 1'b0;
      if (conv_done)
        cmd_stat_r[CONV_DONE_BIT] <= 1'b1;
      else if (conv_start)
        cmd_stat_r[CONV_DONE_BIT] <= 1'b0;
      cmd_stat_r[ANTICOLL_BIT] <= anticollision_support_on;
      if (gain_limit_done)
        cmd_stat_r[GAIN_LIMIT_BIT] <= gain_pending_on_r;
      if (synth_hop_done)
        cmd_stat_r[AUX_SYNTH_BIT] <= hop_pending_aux_r;
      cmd_stat_r[7] <= 1'b0;
    end
  end

  assign events = {1'b0, range_sel_done, supply_set_done, filter_cal_done, conv_done, 3'b000};

  // interrupt status is cleared by reading it; an event in the read cycle stays set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_stat_r <= 8'h00;
    else if (rd_fire && rd_int_stat)
      int_stat_r <= events & EVENT_MASK;
    else
      int_stat_r <= int_stat_r | (events & EVENT_MASK);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(int_stat_r & int_mask_r);
  end

  // write channel: address and data are taken in either order, response after both
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (addr_hit(awaddr_r, PAGE_SEL_ADDR) || addr_hit(awaddr_r, INT_MASK_ADDR) ||
                        addr_hit(awaddr_r, MEAS_SEL_ADDR) || addr_hit(awaddr_r, INT_STAT_ADDR) ||
                        idx_hit(awaddr_r, TUNE_PAGE_IDX) || idx_hit(awaddr_r, CONV_PAGE_IDX) ||
                        idx_hit(awaddr_r, CMD_STAT_IDX) || idx_hit(awaddr_r, VERSION_IDX))
                       ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers; only byte lane 0 carries data, status registers ignore writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      page_sel_r <= PAGE_SEL_RST;
      int_mask_r <= INT_MASK_RST;
      conv_input_select <= MEAS_SEL_RST;
    end
    else if (wr_fire && wstrb_r[0])
    begin
      if (addr_hit(awaddr_r, PAGE_SEL_ADDR))
        page_sel_r <= wdata_r[7:0] & 8'h33;
      if (addr_hit(awaddr_r, INT_MASK_ADDR))
        int_mask_r <= wdata_r[7:0] & EVENT_MASK;
      if (addr_hit(awaddr_r, MEAS_SEL_ADDR))
        conv_input_select <= wdata_r[1:0];
    end
  end

  // read data mux; page registers are pure views of live state
  assign rd_int_stat = addr_hit(s_axi_araddr, INT_STAT_ADDR);

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (idx_hit(s_axi_araddr, TUNE_PAGE_IDX))
    begin
      case (tune_page)
        PAGE_01: rd_data[7:0] = {tuning_range_result, TUNE_RSVD_ONE[0], tuning_pin_level};
        PAGE_10: rd_data[7:0] = {highpass_trim_code, lowpass_trim_code};
        default: rd_data[7:0] = 8'h00;
      endcase
    end
    else if (idx_hit(s_axi_araddr, CONV_PAGE_IDX))
    begin
      case (conv_page)
        PAGE_00: rd_data[7:0] = conv_result_r;
        PAGE_01: rd_data[7:0] = {osc_sync_r[1], 4'h0, supply_level_code};
        default: rd_data[7:0] = 8'h00;
      endcase
    end
    else if (idx_hit(s_axi_araddr, CMD_STAT_IDX))
      rd_data[7:0] = cmd_stat_r;
    else if (idx_hit(s_axi_araddr, VERSION_IDX))
      rd_data[7:0] = DEVICE_VERSION;
    else if (addr_hit(s_axi_araddr, PAGE_SEL_ADDR))
      rd_data[7:0] = page_sel_r;
    else if (rd_int_stat)
      rd_data[7:0] = int_stat_r;
    else if (addr_hit(s_axi_araddr, INT_MASK_ADDR))
      rd_data[7:0] = int_mask_r;
    else if (addr_hit(s_axi_araddr, MEAS_SEL_ADDR))
      rd_data[1:0] = conv_input_select;
    else
      rd_hit = 1'b0;
  end

  // read channel: one read at a time, data one cycle after the address is taken
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : psr_status_bank

// >>> hdl/psr_pkg.sv
// package: register map, field positions and timing for the paged status readout bank
package psr_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] TUNE_PAGE_IDX = 8'h2C;
  localparam logic [7:0] CONV_PAGE_IDX = 8'h2D;
  localparam logic [7:0] CMD_STAT_IDX = 8'h2E;
  localparam logic [7:0] VERSION_IDX = 8'h33;
  // bank-local control and interrupt registers, byte addresses
  localparam logic [11:0] PAGE_SEL_ADDR = 12'h100;
  localparam logic [11:0] INT_STAT_ADDR = 12'h104;
  localparam logic [11:0] INT_MASK_ADDR = 12'h108;
  localparam logic [11:0] MEAS_SEL_ADDR = 12'h10C;
  // page select register fields
  localparam int TUNE_PAGE_LSB = 4;
  localparam int CONV_PAGE_LSB = 0;
  localparam logic [1:0] PAGE_00 = 2'h0;
  localparam logic [1:0] PAGE_01 = 2'h1;
  localparam logic [1:0] PAGE_10 = 2'h2;
  // command status bits; interrupt status and mask share this layout
  localparam int RANGE_DONE_BIT = 6;
  localparam int SUPPLY_DONE_BIT = 5;
  localparam int FILTER_DONE_BIT = 4;
  localparam int CONV_DONE_BIT = 3;
  localparam int ANTICOLL_BIT = 2;
  localparam int GAIN_LIMIT_BIT = 1;
  localparam int AUX_SYNTH_BIT = 0;
  localparam logic [7:0] EVENT_MASK = 8'h78;
  // reset values
  localparam logic [7:0] PAGE_SEL_RST = 8'h00;
  localparam logic [7:0] INT_MASK_RST = 8'h00;
  localparam logic [1:0] MEAS_SEL_RST = 2'h0;
  // converter input selection codes
  localparam logic [1:0] MEAS_MIXER_I = 2'h0;
  localparam logic [1:0] MEAS_MIXER_Q = 2'h1;
  localparam logic [1:0] MEAS_EXT_PIN = 2'h2;
  // direct command codes
  localparam logic [7:0] CMD_HOP_MAIN = 8'h84;
  localparam logic [7:0] CMD_HOP_AUX = 8'h85;
  localparam logic [7:0] CMD_CONV_TRIG = 8'h87;
  localparam logic [7:0] CMD_FILTER_CAL = 8'h88;
  localparam logic [7:0] CMD_SUPPLY_AUTO = 8'hA2;
  localparam logic [7:0] CMD_SUPPLY_MAN = 8'hA3;
  localparam logic [7:0] CMD_RANGE_AUTO = 8'hA4;
  localparam logic [7:0] CMD_RANGE_MAN = 8'hA5;
  localparam logic [7:0] CMD_GAIN_ON = 8'hA6;
  localparam logic [7:0] CMD_GAIN_OFF = 8'hA7;
  // timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CONV_TIME_US = 20;
  localparam int CONV_CYCLES = (CONV_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // axi responses, then the value of the tuning view bit that reads one
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] TUNE_RSVD_ONE = 3'h1;
endpackage : psr_pkg

// >>> hdl/psr_conv_timer.sv
// conversion settle timer: one-cycle done pulse a fixed number of cycles after start
`timescale 1ns/100ps
module psr_conv_timer #(
  parameter int CYCLES = psr_pkg::CONV_CYCLES,
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  import psr_pkg::*;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
  logic [CNT_W-1:0] cnt_r;

  // a new start while busy restarts the wait, so the result always follows the latest trigger
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_r <= '0;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt_r == LAST)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + CNT_W'(1);
        end
      end
    end
  end
endmodule : psr_conv_timer

// >>> test/psr_status_bank_asserts.sv
// checker: bus handshake and converter timing assertions for the status bank
`timescale 1ns/100ps
module psr_status_bank_asserts #(
  parameter int CONV_CYCLES_P = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read and write channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // command side
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic conv_busy
);
  import psr_pkg::*;
  // a restart pushes the end out, so the bound counts from the latest trigger
  localparam int CONV_MAX = CONV_CYCLES_P + 4;
  logic [15:0] since_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (cmd_strobe && cmd_code == CMD_CONV_TRIG))
      since_r <= 16'h0000;
    else if (since_r != 16'hFFFF)
      since_r <= since_r + 16'h0001;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence conv_start;
    cmd_strobe && cmd_code == CMD_CONV_TRIG;
  endsequence
  sequence busy_run;
    conv_busy [*6];
  endsequence
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before it was taken");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered one cycle after take");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_conv_start: assert property (conv_start |-> ##[1:3] conv_busy)
    else $error("converter did not start");
  a_conv_run: assert property ($rose(conv_busy) |-> busy_run)
    else $error("converter settle ended early");
  a_busy_bound: assert property (conv_busy |-> since_r <= CONV_MAX)
    else $error("converter settle ran too long");
endmodule : psr_status_bank_asserts

bind psr_status_bank psr_status_bank_asserts #(.CONV_CYCLES_P(CONV_CYCLES_P)) u_asserts (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .cmd_strobe, .cmd_code, .conv_busy
);

// >>> test/psr_host_model.sv
// host model: axi4-lite master reading and writing the status bank
`timescale 1ns/100ps
module psr_host_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  // wait limit ran out
  output logic hang
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, hang} = '0;
  end
  // handshakes are judged at the falling edge, where registered slave outputs are settled
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    r = 2'h3;
    for (n = 0; n < 200 && !tb; n++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) hang <= 1'b1;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    for (n = 0; n < 200 && !tr; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) hang <= 1'b1;
  endtask : rd
endmodule : psr_host_model

// >>> test/testbench.sv
// testbench: paged views, command flags, interrupt and converter of the status bank
`timescale 1ns/100ps
module testbench;
  import psr_pkg::*;
  logic aclk, aresetn, cmd_strobe, osc_input_grounded, anticollision_support_on, hang;
  logic range_sel_done, supply_set_done, filter_cal_done, gain_limit_done, synth_hop_done;
  logic [7:0] cmd_code, adc_sample;
  logic [3:0] tuning_range_result, highpass_trim_code, lowpass_trim_code, s_axi_wstrb;
  logic [2:0] tuning_pin_level, supply_level_code;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, conv_input_select, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, conv_busy, irq;
  int err_count, n_tests;
  // page setting, view address, expected byte
  logic [27:0] rows [10] = '{{8'h10, 12'h0B0, 8'hAD}, {8'h20, 12'h0B0, 8'h3C}, {8'h00, 12'h0B0, 8'h00},
    {8'h30, 12'h0B0, 8'h00}, {8'h01, 12'h0B4, 8'h86}, {8'h02, 12'h0B4, 8'h00}, {8'h03, 12'h0B4, 8'h00},
    {8'h00, 12'h0CC, 8'h5A}, {8'h31, 12'h100, 8'h31}, {8'h00, 12'h0B8, 8'h04}};
  logic [7:0] ev_cmd [6] = '{8'hA4, 8'hA5, 8'hA2, 8'hA3, 8'h88, 8'h87};
  logic [4:0] ev_pls [6] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h00};
  int ev_bit [6] = '{RANGE_DONE_BIT, RANGE_DONE_BIT, SUPPLY_DONE_BIT, SUPPLY_DONE_BIT, FILTER_DONE_BIT, CONV_DONE_BIT};
  psr_status_bank #(.DEVICE_VERSION(8'h5A), .CONV_CYCLES_P(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmd_strobe, .cmd_code, .range_sel_done, .supply_set_done, .filter_cal_done, .gain_limit_done, .synth_hop_done,
    .tuning_range_result, .tuning_pin_level, .highpass_trim_code, .lowpass_trim_code, .adc_sample,
    .supply_level_code, .anticollision_support_on, .osc_input_grounded, .conv_input_select, .conv_busy, .irq);
  psr_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hang);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  always @(posedge aclk)
  begin
    if (hang === 1'b1)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] msk);
    host.rd(a, v, rs);
    chk($sformatf("reg %h", a), v & {24'hFFFFFF, msk}, {24'h000000, exp & msk});
  endtask : rchk
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    host.wr(a, d, rs);
  endtask : wreg
  task automatic cmd(input logic [7:0] c);
    @(posedge aclk);
    cmd_strobe <= 1'b1;
    cmd_code <= c;
    @(posedge aclk);
    cmd_strobe <= 1'b0;
  endtask : cmd
  task automatic ev(input logic [4:0] m);
    @(posedge aclk);
    {synth_hop_done, gain_limit_done, filter_cal_done, supply_set_done, range_sel_done} <= m;
    @(posedge aclk);
    {synth_hop_done, gain_limit_done, filter_cal_done, supply_set_done, range_sel_done} <= 5'h00;
  endtask : ev
  initial
  begin
    {aresetn, cmd_strobe, range_sel_done, supply_set_done, filter_cal_done, gain_limit_done, synth_hop_done} = '0;
    {cmd_code, adc_sample, err_count, n_tests} = '0;
    {tuning_range_result, tuning_pin_level, highpass_trim_code, lowpass_trim_code} = {4'hA, 3'h5, 4'h3, 4'hC};
    {supply_level_code, osc_input_grounded, anticollision_support_on} = {3'h6, 1'b1, 1'b1};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(INT_MASK_ADDR, INT_MASK_RST, 8'hFF);
    rchk(MEAS_SEL_ADDR, 8'h00, 8'hFF);
    for (int i = 0; i < 10; i++)
    begin
      wreg(PAGE_SEL_ADDR, rows[i][27:20]);
      rchk(rows[i][19:8], rows[i][7:0], 8'hFF);
    end
    host.rd(12'h0F0, v, rs);
    chk("unmapped read", {v[29:0], rs}, {30'h0, RESP_SLVERR});
    host.wr(12'h0F4, 8'h55, rs);
    chk("unmapped write", rs, RESP_SLVERR);
    host.wr(12'h0CC, 8'h12, rs);
    rchk(12'h0CC, 8'h5A, 8'hFF);
    wreg(INT_MASK_ADDR, 8'hFF);
    rchk(INT_MASK_ADDR, EVENT_MASK, 8'hFF);
    for (int i = 0; i < 6; i++)
    begin
      cmd(ev_cmd[i]);
      if (ev_pls[i] != 5'h00) ev(ev_pls[i]);
      else repeat (12) @(posedge aclk);
      rchk(12'h0B8, 8'hFF, 8'h01 << ev_bit[i]);
      chk("irq set", irq, 1'b1);
      rchk(INT_STAT_ADDR, 8'h01 << ev_bit[i], 8'hFF);
      @(posedge aclk);
      chk("irq cleared", irq, 1'b0);
    end
    // a masked event still sets its status bit but must not raise the line
    wreg(INT_MASK_ADDR, 8'h00);
    cmd(CMD_RANGE_AUTO);
    ev(5'h01);
    repeat (3) @(posedge aclk);
    chk("irq masked", irq, 1'b0);
    rchk(INT_STAT_ADDR, 8'h40, 8'hFF);
    wreg(PAGE_SEL_ADDR, 8'h00);
    adc_sample <= 8'h9B;
    cmd(CMD_CONV_TRIG);
    rchk(12'h0B4, 8'h00, 8'hFF);
    repeat (12) @(posedge aclk);
    rchk(12'h0B4, 8'h9B, 8'hFF);
    rchk(12'h0B4, 8'h9B, 8'hFF);
    for (int i = 0; i < 4; i++)
    begin
      cmd((i < 2) ? CMD_GAIN_ON + i[7:0] : CMD_HOP_AUX + 8'h02 - i[7:0]);
      ev((i < 2) ? 5'h08 : 5'h10);
      rchk(12'h0B8, {6'h00, ~i[0], ~i[0]}, (i < 2) ? 8'h02 : 8'h01);
    end
    cmd(CMD_HOP_AUX);
    ev(5'h10);
    rchk(12'h0B8, 8'h01, 8'h01);
    cmd(CMD_HOP_MAIN);
    ev(5'h10);
    rchk(12'h0B8, 8'h00, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      wreg(MEAS_SEL_ADDR, i[7:0]);
      chk("input select", conv_input_select, i[1:0]);
    end
    anticollision_support_on <= 1'b0;
    rchk(12'h0B8, 8'h00, 8'h04);
    // crystal case of the oscillator detect pin, and a non-reset page setting for the reset check
    osc_input_grounded <= 1'b0;
    wreg(PAGE_SEL_ADDR, 8'h21);
    rchk(12'h0B4, 8'h06, 8'hFF);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(PAGE_SEL_ADDR, PAGE_SEL_RST, 8'hFF);
    rchk(12'h0B8, 8'h00, 8'hFB);
    wrap_up();
  end
endmodule : testbench
